//--- cmf_pkg.sv
// Shared constants of the mailbox status flag block.
// Assumes nothing beyond a SystemVerilog compiler; no timescale here.
package cmf_pkg;
   // Mailbox counts and message field widths.
   localparam int NMB        = 16;
   localparam int NTX        = 15;
   localparam int RX_ONLY_MB = 15;
   localparam int IDW        = 29;
   localparam int CTW        = 4;
   localparam int DW         = 64;
   localparam int MW         = IDW + CTW + DW;
   localparam int MAW        = 4;
   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0] IDX_ABORT_LOW  = 10'h30A;
   localparam logic [9:0] IDX_ABORT_HIGH = 10'h30B;
   localparam logic [9:0] IDX_RXP_LOW    = 10'h30C;
   localparam logic [9:0] IDX_RXP_HIGH   = 10'h30D;
   localparam logic [9:0] IDX_LOST_LOW   = 10'h30E;
   localparam logic [9:0] IDX_LOST_HIGH  = 10'h30F;
   localparam logic [9:0] IDX_LOCK_LOW   = 10'h32A;
   localparam logic [9:0] IDX_LOCK_HIGH  = 10'h32B;
   // Field positions: low byte holds mailboxes 0 to 7, high byte 8 up.
   localparam int LOW_LSB  = 0;
   localparam int HIGH_LSB = 8;
   // Reset values.
   localparam logic [14:0] RST_TX15 = 15'h0000;
   localparam logic [15:0] RST_RX16 = 16'h0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // Cycles from a taken bus request to its acknowledge.
   localparam int ACK_CYCLES = 1;
endpackage

//--- cmf_mem_if.sv
// Carrier between the flag logic and the mailbox contents memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cmf_mem_if;
   logic                   we;
   logic [cmf_pkg::MAW-1:0] wa;
   logic [cmf_pkg::MW-1:0]  wd;
   logic [cmf_pkg::MAW-1:0] ra;
   logic [cmf_pkg::MW-1:0]  rd;
   modport ctl (output we, output wa, output wd, output ra, input rd);
   modport mem (input we, input wa, input wd, input ra, output rd);
endinterface
`default_nettype wire

//--- cmf_mbox_mem.sv
// Sixteen-entry store of received identifier, control bits and data.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/1ps
`default_nettype none
module cmf_mbox_mem (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   cmf_mem_if.mem   m
);
   logic [cmf_pkg::MW-1:0] store [cmf_pkg::NMB];

   // The array has no reset so it maps onto plain RAM.
   always_ff @(posedge core_clk_i) begin
      if (clk_en_i && m.we) begin
         store[m.wa] <= m.wd;
      end
   end

   // Registered read port.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         m.rd <= '0;
      end else if (clk_en_i) begin
         m.rd <= store[m.ra];
      end
   end
endmodule
`default_nettype wire

//--- cmf_flags.sv
// Mailbox status flags: abort acknowledge, transmit lock, receive
// matching with pending and lost flags, and a classic Wishbone slave.
// Assumes all inputs synchronous to core_clk_i at 50 MHz.
// Notes on behaviour
// - Aborted transmission sets mailbox abort flag; pulse abort interrupt if enabled.
// - Writing one to abort flag or transmit request clears abort flag.
// - Abort and lock vectors hold mailboxes 0 to 14 only.
// - Locked mailbox is ignored for transmit and left out of arbitration.
// - Identifier compare masked by global or local mask per mailbox enable; the local mask serves mailbox 15 only.
// - Match stores message, sets pending flag, pulses receive interrupt.
// - Only the first matching mailbox receives the message.
// - No match discards message; no mailbox or flag changes.
// - Arrival while pending overwrites, sets lost flag, pulses lost interrupt.
// - Mailbox 15 compared only when mailboxes 0 to 14 missed.
// - Pending set by hardware only; software write of one clears.
// - Pending vector has sixteen bits, mailbox 15 included.
// - Lost flag cleared by one written to pending; direct writes ignored.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cmf_flags (
   input  wire logic                             core_clk_i,
   input  wire logic                             resetn_i,
   input  wire logic                             clk_en_i,
   // Wishbone slave.
   input  wire logic                             wb_cyc_i,
   input  wire logic                             wb_stb_i,
   input  wire logic                             wb_we_i,
   input  wire logic [11:0]                      wb_adr_i,
   input  wire logic [3:0]                       wb_sel_i,
   input  wire logic [31:0]                      wb_dat_i,
   output logic      [31:0]                      wb_dat_o,
   output logic                                  wb_ack_o,
   // Transmit side.
   input  wire logic [cmf_pkg::NTX-1:0]          abort_evt_i,
   input  wire logic [cmf_pkg::NTX-1:0]          tx_req_wr_i,
   input  wire logic [cmf_pkg::NTX-1:0]          tx_req_i,
   output logic      [cmf_pkg::NTX-1:0]          tx_arb_o,
   // Receive side.
   input  wire logic                             rx_valid_i,
   input  wire logic [cmf_pkg::IDW-1:0]          rx_id_i,
   input  wire logic [cmf_pkg::CTW-1:0]          rx_ctrl_i,
   input  wire logic [cmf_pkg::DW-1:0]           rx_data_i,
   input  wire logic [cmf_pkg::NMB*cmf_pkg::IDW-1:0] mb_id_i,
   input  wire logic [cmf_pkg::NTX-1:0]          mb_dir_rx_i,
   input  wire logic [cmf_pkg::NMB-1:0]          global_mask_enable_i,
   input  wire logic                             local_mask_enable_i,
   input  wire logic [cmf_pkg::IDW-1:0]          global_mask_regs_i,
   input  wire logic [cmf_pkg::IDW-1:0]          local_mask_regs_i,
   // Mailbox contents read port.
   input  wire logic [cmf_pkg::MAW-1:0]          mb_rd_addr_i,
   output logic      [cmf_pkg::MW-1:0]           mb_rd_data_o,
   // Global interrupt requests, one-cycle pulses.
   input  wire logic                             abort_irq_en_i,
   input  wire logic                             rx_irq_en_i,
   input  wire logic                             lost_irq_en_i,
   output logic                                  abort_irq_o,
   output logic                                  rx_irq_o,
   output logic                                  lost_irq_o
);
   localparam int NTX = cmf_pkg::NTX;
   localparam int NMB = cmf_pkg::NMB;
   localparam int IDW = cmf_pkg::IDW;
   localparam int HL  = cmf_pkg::HIGH_LSB;
   localparam int LL  = cmf_pkg::LOW_LSB;

   logic [NTX-1:0] abort_flag;
   logic [NTX-1:0] lock_flag;
   logic [NMB-1:0] rxp_flag;
   logic [NMB-1:0] lost_flag;
   logic [NMB-1:0] hit;
   logic [NMB-1:0] store_vec;
   logic           found;
   logic           req;
   logic           wr;
   logic [9:0]     idx;
   logic [7:0]     wbyte;
   logic [31:0]    next_rdata;
   logic [NTX-1:0] abort_wclr;
   logic [NTX-1:0] abort_clr;
   logic [NMB-1:0] rxp_wclr;
   logic [NMB-1:0] lost_set;

   cmf_mem_if mif ();

   // Bus decode; a write lands on the edge where the master sees ack.
   assign req   = wb_cyc_i && wb_stb_i;
   assign idx   = wb_adr_i[11:2];
   assign wr    = req && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   // Acknowledge one cycle after the request, then drop for a cycle.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_ack_o <= 1'b0;
      end else if (clk_en_i) begin
         wb_ack_o <= req && !wb_ack_o;
      end
   end

   // Read mux; unmapped indices read zero and are still acknowledged.
   always_comb begin
      next_rdata = cmf_pkg::RST_WORD;
      case (idx)
         cmf_pkg::IDX_ABORT_LOW: begin
            next_rdata[7:0] = abort_flag[HL-1:LL];
         end
         cmf_pkg::IDX_ABORT_HIGH: begin
            next_rdata[6:0] = abort_flag[NTX-1:HL];
         end
         cmf_pkg::IDX_RXP_LOW: begin
            next_rdata[7:0] = rxp_flag[HL-1:LL];
         end
         cmf_pkg::IDX_RXP_HIGH: begin
            next_rdata[7:0] = rxp_flag[NMB-1:HL];
         end
         cmf_pkg::IDX_LOST_LOW: begin
            next_rdata[7:0] = lost_flag[HL-1:LL];
         end
         cmf_pkg::IDX_LOST_HIGH: begin
            next_rdata[7:0] = lost_flag[NMB-1:HL];
         end
         cmf_pkg::IDX_LOCK_LOW: begin
            next_rdata[7:0] = lock_flag[HL-1:LL];
         end
         cmf_pkg::IDX_LOCK_HIGH: begin
            next_rdata[6:0] = lock_flag[NTX-1:HL];
         end
         default: begin
            next_rdata = cmf_pkg::RST_WORD;
         end
      endcase
   end

   // Read data are captured together with the rising ack.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_dat_o <= cmf_pkg::RST_WORD;
      end else if (clk_en_i && req && !wb_ack_o) begin
         wb_dat_o <= next_rdata;
      end
   end

   // Write-one-to-clear masks taken from the written byte.
   always_comb begin
      abort_wclr = '0;
      rxp_wclr   = '0;
      if (wr && idx == cmf_pkg::IDX_ABORT_LOW) begin
         abort_wclr[HL-1:LL] = wbyte;
      end
      if (wr && idx == cmf_pkg::IDX_ABORT_HIGH) begin
         abort_wclr[NTX-1:HL] = wbyte[6:0];
      end
      if (wr && idx == cmf_pkg::IDX_RXP_LOW) begin
         rxp_wclr[HL-1:LL] = wbyte;
      end
      if (wr && idx == cmf_pkg::IDX_RXP_HIGH) begin
         rxp_wclr[NMB-1:HL] = wbyte;
      end
   end

   // A one written to the transmit request also acknowledges the abort.
   assign abort_clr = abort_wclr | tx_req_wr_i;

   // Abort flags: the set term is ORed last so an abort is never lost to a clear in the same cycle.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         abort_flag <= cmf_pkg::RST_TX15;
      end else if (clk_en_i) begin
         abort_flag <= (abort_flag & ~abort_clr) | abort_evt_i;
      end
   end

   // Lock flags are plain read/write bits.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lock_flag <= cmf_pkg::RST_TX15;
      end else if (clk_en_i && wr) begin
         if (idx == cmf_pkg::IDX_LOCK_LOW) begin
            lock_flag[HL-1:LL] <= wbyte;
         end
         if (idx == cmf_pkg::IDX_LOCK_HIGH) begin
            lock_flag[NTX-1:HL] <= wbyte[6:0];
         end
      end
   end

   // A locked mailbox stays out of arbitration until unlocked.
   assign tx_arb_o = tx_req_i & ~lock_flag;

   // Per-mailbox masked compare; a mask bit of one means do not care.
   // Mailbox 15 is always a receiver and alone may use the local mask.
   for (genvar g = 0; g < NMB; g++) begin : g_cmp
      logic [IDW-1:0] mask;
      logic           is_rx;
      if (g == cmf_pkg::RX_ONLY_MB) begin : g_last
         assign is_rx = 1'b1;
         assign mask  = global_mask_enable_i[g] ? global_mask_regs_i
                      : local_mask_enable_i ? local_mask_regs_i : '0;
      end else begin : g_tx
         assign is_rx = mb_dir_rx_i[g];
         assign mask  = global_mask_enable_i[g] ? global_mask_regs_i : '0;
      end
      assign hit[g] = is_rx && (((rx_id_i ^ mb_id_i[g*IDW +: IDW]) & ~mask) == '0);
   end

   // Lowest matching mailbox wins; mailbox 15 only as fallback.
   always_comb begin
      store_vec = '0;
      found     = 1'b0;
      for (int i = 0; i < NTX; i++) begin
         if (!found && hit[i]) begin
            store_vec[i] = rx_valid_i;
            found        = 1'b1;
         end
      end
      if (!found && hit[cmf_pkg::RX_ONLY_MB]) begin
         store_vec[cmf_pkg::RX_ONLY_MB] = rx_valid_i;
      end
   end

   // Lost is flagged when the target still holds an unread message.
   assign lost_set = store_vec & rxp_flag;

   // Pending flags: hardware set wins over the software clear.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rxp_flag <= cmf_pkg::RST_RX16;
      end else if (clk_en_i) begin
         rxp_flag <= (rxp_flag & ~rxp_wclr) | store_vec;
      end
   end

   // Lost flags clear only through a one written to pending.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lost_flag <= cmf_pkg::RST_RX16;
      end else if (clk_en_i) begin
         lost_flag <= (lost_flag & ~rxp_wclr) | lost_set;
      end
   end

   // Global interrupt pulses, registered one cycle after the event.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         abort_irq_o <= 1'b0;
         rx_irq_o    <= 1'b0;
         lost_irq_o  <= 1'b0;
      end else if (clk_en_i) begin
         abort_irq_o <= abort_irq_en_i && (|abort_evt_i);
         rx_irq_o    <= rx_irq_en_i && (|store_vec);
         lost_irq_o  <= lost_irq_en_i && (|lost_set);
      end
   end

   // A miss leaves the write enable low, so nothing is stored.
   assign mif.we = |store_vec;
   assign mif.wd = {rx_id_i, rx_ctrl_i, rx_data_i};
   assign mif.ra = mb_rd_addr_i;
   assign mb_rd_data_o = mif.rd;

   // Encode the one-hot target into a write address.
   always_comb begin
      mif.wa = '0;
      for (int i = 0; i < NMB; i++) begin
         if (store_vec[i]) begin
            mif.wa = cmf_pkg::MAW'(i);
         end
      end
   end

   cmf_mbox_mem u_mem (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .clk_en_i   (clk_en_i),
      .m          (mif.mem)
   );

   // Checks, all on the one clock and disabled in reset.
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_req;
      clk_en_i && req && !wb_ack_o;
   endsequence

   // Any mailbox, the fallback included, takes the frame in this cycle.
   sequence s_store;
      clk_en_i && (store_vec != '0);
   endsequence

   property p_ack;
      s_req |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("Bus request not acknowledged.");

   property p_abort_set;
      clk_en_i && (abort_evt_i != '0) |=> ((abort_flag & $past(abort_evt_i)) == $past(abort_evt_i));
   endproperty
   a_abort_set: assert property (p_abort_set) else $error("Abort flag missed.");

   property p_abort_clr;
      clk_en_i && (abort_evt_i == '0) && (abort_clr != '0) |=> ((abort_flag & $past(abort_clr)) == '0);
   endproperty
   a_abort_clr: assert property (p_abort_clr) else $error("Abort flag not cleared.");

   property p_lock;
      (tx_arb_o & lock_flag) == '0;
   endproperty
   a_lock: assert property (p_lock) else $error("Locked mailbox in arbitration.");

   property p_first;
      $onehot0(store_vec) && ((store_vec & ~hit) == '0);
   endproperty
   a_first: assert property (p_first) else $error("More than one mailbox written.");

   property p_fallback;
      store_vec[cmf_pkg::RX_ONLY_MB] |-> (hit[NTX-1:0] == '0);
   endproperty
   a_fallback: assert property (p_fallback) else $error("Fallback taken despite match.");

   property p_pend;
      s_store |=> ((rxp_flag & $past(store_vec)) == $past(store_vec));
   endproperty
   a_pend: assert property (p_pend) else $error("Pending flag not set.");

   property p_miss;
      clk_en_i && rx_valid_i && !(|hit) && (rxp_wclr == '0) |=> $stable(rxp_flag) && $stable(lost_flag);
   endproperty
   a_miss: assert property (p_miss) else $error("Miss changed a flag.");

   property p_lost;
      s_store ##0 ((store_vec & rxp_flag) != '0) |=> ((lost_flag & $past(store_vec)) != '0);
   endproperty
   a_lost: assert property (p_lost) else $error("Lost flag not set.");

   property p_lost_irq;
      clk_en_i && lost_irq_en_i && (lost_set != '0) |=> lost_irq_o;
   endproperty
   a_lost_irq: assert property (p_lost_irq) else $error("Lost interrupt missing.");
endmodule
`default_nettype wire

//--- cmf_can_node.sv
// Model of a CAN node whose frames reach the flag block via the controller.
// Assumes the bench asks for one frame per send_i pulse on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module cmf_can_node (
   input  wire logic                    core_clk_i,
   input  wire logic                    resetn_i,
   input  wire logic                    send_i,
   input  wire logic [cmf_pkg::MW-1:0]  msg_i,
   output logic                         rx_valid_o,
   output logic      [cmf_pkg::MW-1:0]  msg_o
);
   // Between frames the fields flip every cycle, so a stale value never passes for a fresh one.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_valid_o <= 1'b0;
         msg_o      <= {cmf_pkg::MW{1'b1}};
      end else begin
         rx_valid_o <= send_i;
         msg_o      <= send_i ? msg_i : ~msg_o;
      end
   end
endmodule
`default_nettype wire

//--- tb_can_mailbox_status_flags.sv
// Self-checking bench of the mailbox flag block with a CAN node model.
// Assumes the design acknowledges each bus request and takes one frame per pulse.
`timescale 1ns/1ps
`default_nettype none
module tb_can_mailbox_status_flags;
   logic        clk, rstn, cyc, stb, we, ack, send, rxv, ia, ir, il, ce, lme;
   logic [11:0] adr;
   logic [31:0] wdat, rdat, seed;
   logic [14:0] abt, trw, treq, arb, dir;
   logic [15:0] gme, e_rxp, e_lost;
   logic [28:0] gmask, lmask;
   logic [463:0] mb_id;
   logic [96:0] msg, rmsg, rd_data;
   logic [3:0]  rd_addr;
   logic [7:0]  q;
   int          fails, n_checks, n_a, n_r, n_l, e_r, e_l;
   logic [9:0]  regs [8] = '{10'h30A, 10'h30B, 10'h30C, 10'h30D, 10'h30E, 10'h30F, 10'h32A, 10'h32B};

   cmf_can_node node (.core_clk_i(clk), .resetn_i(rstn), .send_i(send), .msg_i(msg), .rx_valid_o(rxv), .msg_o(rmsg));
   cmf_flags dut (.core_clk_i(clk), .resetn_i(rstn), .clk_en_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .abort_evt_i(abt), .tx_req_wr_i(trw), .tx_req_i(treq), .tx_arb_o(arb), .rx_valid_i(rxv),
      .rx_id_i(rmsg[96:68]), .rx_ctrl_i(rmsg[67:64]), .rx_data_i(rmsg[63:0]), .mb_id_i(mb_id),
      .mb_dir_rx_i(dir), .global_mask_enable_i(gme), .local_mask_enable_i(lme), .global_mask_regs_i(gmask),
      .local_mask_regs_i(lmask), .mb_rd_addr_i(rd_addr), .mb_rd_data_o(rd_data), .abort_irq_en_i(1'b1),
      .rx_irq_en_i(1'b1), .lost_irq_en_i(1'b1), .abort_irq_o(ia), .rx_irq_o(ir), .lost_irq_o(il));

   // The clock runs at 50 MHz.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Interrupt pulses are counted, so their exact cycle does not matter here.
   always @(posedge clk) begin
      if (ia === 1'b1) n_a++;
      if (ir === 1'b1) n_r++;
      if (il === 1'b1) n_l++;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // First receive mailbox whose masked identifier matches; 16 means none.
   function automatic int hit(input logic [28:0] id);
      logic [28:0] m;
      for (int n = 0; n < 16; n++) begin
         m = gme[n] ? gmask : (n == 15 && lme) ? lmask : 29'h0;
         if ((n == 15 || dir[n]) && ((mb_id[n*29 +: 29] ^ id) & ~m) == 29'h0) return n;
      end
      return 16;
   endfunction

   task automatic chk(input logic [96:0] got, input logic [96:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic Wishbone cycle; everything is held until ack is sampled.
   task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(q, e);
   endtask

   task automatic flags();
      rdc(10'h30C, e_rxp[7:0]);
      rdc(10'h30D, e_rxp[15:8]);
      rdc(10'h30E, e_lost[7:0]);
      rdc(10'h30F, e_lost[15:8]);
   endtask

   // Sends one frame and checks the flags and the stored copy.
   task automatic rx(input logic [28:0] id);
      int e;
      logic [31:0] a, b;
      e = hit(id);
      a = rnd();
      b = rnd();
      msg <= {id, a[3:0], a, b};
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (3) @(posedge clk);
      if (e < 16) begin
         if (e_rxp[e]) e_l++;
         e_lost[e] |= e_rxp[e];
         e_rxp[e] = 1'b1;
         e_r++;
         rd_addr <= e[3:0];
         repeat (2) @(posedge clk);
         chk(rd_data, {id, a[3:0], a, b});
      end
      flags();
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      wrap_up();
   end

   initial begin
      logic [31:0] v;
      {rstn, cyc, stb, we, send, adr, wdat, abt, trw, treq, gme, gmask, msg, rd_addr, lme, lmask} = '0;
      ce = 1'b1;
      {fails, n_checks, n_a, n_r, n_l, e_r, e_l, e_rxp, e_lost} = '0;
      dir = 15'h7FFF;
      seed = 32'h9665;
      for (int n = 0; n < 16; n++) mb_id[n*29 +: 29] = rnd();
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (regs[i]) rdc(regs[i], 8'h00);
      rdc(10'h100, 8'h00);
      // Lock: bit 15 absent, locked requests leave arbitration.
      bus(1'b1, 10'h32B, 8'hFF);
      rdc(10'h32B, 8'h7F);
      v = rnd();
      bus(1'b1, 10'h32A, v[7:0]);
      bus(1'b1, 10'h32B, v[15:8]);
      treq <= v[30:16];
      @(posedge clk);
      #1 chk(arb, v[30:16] & ~v[14:0]);
      bus(1'b1, 10'h32A, 8'h00);
      bus(1'b1, 10'h32B, 8'h00);
      #1 chk(arb, v[30:16]);
      @(posedge clk);
      // Abort flags and their clearing paths.
      abt <= 15'h7FFF;
      @(posedge clk);
      abt <= 15'h0;
      repeat (2) @(posedge clk);
      rdc(10'h30B, 8'h7F);
      chk(n_a, 1);
      bus(1'b1, 10'h30A, 8'h00);
      rdc(10'h30A, 8'hFF);
      bus(1'b1, 10'h30A, 8'h01);
      rdc(10'h30A, 8'hFE);
      trw <= 15'h0100;
      @(posedge clk);
      trw <= 15'h0;
      @(posedge clk);
      rdc(10'h30B, 8'h7E);
      // Clock enable low: an abort in a frozen cycle must not be taken.
      ce <= 1'b0;
      abt <= 15'h0001;
      @(posedge clk);
      abt <= 15'h0;
      ce <= 1'b1;
      @(posedge clk);
      rdc(10'h30A, 8'hFE);
      chk(n_a, 1);
      // Receive matching, priority, fallback, overwrite and masking.
      rx(mb_id[3*29 +: 29]);
      mb_id[5*29 +: 29] <= mb_id[2*29 +: 29];
      mb_id[15*29 +: 29] <= mb_id[7*29 +: 29];
      dir <= 15'h7F7F;
      @(posedge clk);
      rx(mb_id[2*29 +: 29]);
      rx(mb_id[4*29 +: 29]);
      rx(mb_id[7*29 +: 29]);
      rx(~mb_id[0 +: 29]);
      rx(mb_id[3*29 +: 29]);
      gmask <= 29'h1;
      gme <= 16'h0040;
      @(posedge clk);
      rx(mb_id[6*29 +: 29] ^ 29'h1);
      // The local mask reaches only the fallback mailbox.
      lmask <= 29'h2;
      lme <= 1'b1;
      @(posedge clk);
      rx(mb_id[7*29 +: 29] ^ 29'h2);
      for (int i = 0; i < 6; i++) begin
         v = rnd();
         rx(mb_id[v[3:0]*29 +: 29]);
      end
      // Clearing: zeros and direct lost writes change nothing.
      bus(1'b1, 10'h30C, 8'h00);
      bus(1'b1, 10'h30E, 8'hFF);
      flags();
      bus(1'b1, 10'h30C, 8'h08);
      bus(1'b1, 10'h30D, 8'h80);
      e_rxp &= 16'h7FF7;
      e_lost &= 16'h7FF7;
      flags();
      chk(n_r, e_r);
      chk(n_l, e_l);
      wrap_up();
   end
endmodule
`default_nettype wire
